// ### mgmt_client.sv
// Functional notes
// [RQ1] answer only phy addresses with bit four set
// [RQ2] register mode only when strap sampled zero
// [RQ3] ignore pins until initialization completes
// [RQ4] ignore pins outside fully powered state
// [RQ5] frames carry 16 data, 5+5 address bits
// [RQ6] phy bits 3:0 to 9:6, reg to 5:1; code then clears addr bit 1, so only reg 4:1 land at 5:2
// [RQ7] half select pairs two frames into one word
// [RQ8] host keeps halves atomic with equal address
// [RQ9] sample and launch on rising clock edge
// [RQ10] data line released unless driving read data
// [RQ11] msb first, little endian byte order
// [RQ12] select one gives bytes 3,2; zero 1,0
// [RQ13] read: turnaround z then zero, then data
// [RQ14] write: host turnaround one then zero
// [RQ15] nobody drives the idle line
// [RQ16] preamble, start, opcode, addresses, turnaround, data
// [RQ17] same half read twice restarts pairing
// [RQ18] capture all 32 bits at first half
// [RQ19] unused addresses read back as zero
// [RQ20] start 01, read 10, write 01, else ignored
// [RQ21] count edges after preamble, drop bad start
`include "mgmt_cfg.svh"

module mgmt_client
  import mgmt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  mgmt_if.device mgmt,
  input wire logic mode_strap,
  input wire logic init_done,
  input wire logic fully_powered,
  output logic [9:0] reg_addr,
  output logic rd_strobe,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit,
  output logic rd_done,
  output logic wr_strobe,
  output logic [31:0] wr_data
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // pick the half of a word that a frame carries, upper half when sel is one
  function automatic logic [15:0] half_of(input logic [31:0] word, input logic sel);
    half_of = sel ? word[31:16] : word[15:0]; // see [RQ12]
  endfunction

  dev_regs_type s_r; // registered state
  dev_regs_type s_nxt; // next state
  logic edge_seen; // rising edge of the synchronised management clock
  logic bit_in; // line level sampled at that edge
  logic active; // client may react to the pins

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // one process holds all decisions; pulses default low every cycle
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd_strobe = 1'b0;
    s_nxt.rd_done = 1'b0;
    s_nxt.wr_strobe = 1'b0;
    // pin inputs pass two flops before anything looks at them
    s_nxt.mdc_s1 = mgmt.mdc;
    s_nxt.mdc_s2 = s_r.mdc_s1;
    s_nxt.mdc_d = s_r.mdc_s2;
    s_nxt.dio_s1 = mgmt.mdio;
    s_nxt.dio_s2 = s_r.dio_s1;
    s_nxt.strap_s1 = mode_strap;
    s_nxt.strap_s2 = s_r.strap_s1;
    edge_seen = s_r.mdc_s2 && !s_r.mdc_d; // see [RQ9]
    bit_in = s_r.dio_s2; // see [RQ9]
    // the strap is taken once, after the synchroniser has settled
    if (s_r.strap_wait != `MGMT_STRAP_SETTLE)
    begin
      s_nxt.strap_wait = s_r.strap_wait + 2'h1;
      if (s_r.strap_wait == `MGMT_STRAP_SETTLE - 2'h1)
      begin
        s_nxt.mode_ok = (s_r.strap_s2 == `MGMT_STRAP_REG_MODE); // see [RQ2]
      end
    end
    active = s_r.mode_ok && init_done && fully_powered; // see [RQ2] [RQ3] [RQ4]
    // a read capture asked for last cycle lands in the first turnaround
    if (s_r.rd_strobe)
    begin
      s_nxt.rd_hold = rd_hit ? rd_data : 32'h0; // see [RQ18] [RQ19]
      s_nxt.shift = half_of(s_nxt.rd_hold, s_r.cur_sel); // see [RQ12]
    end
    if (!active)
    begin
      // pairing state is left alone so nothing is affected by pin activity
      s_nxt.state = st_idle; // see [RQ3] [RQ4]
      s_nxt.ones = 6'h0;
      s_nxt.dio_oe_n = `MGMT_OE_OFF; // see [RQ10]
    end
    else if (edge_seen)
    begin
      case (s_r.state)
        // count ones; a zero after a full preamble is the first start bit
        st_idle:
        begin
          s_nxt.dio_oe_n = `MGMT_OE_OFF; // see [RQ15]
          if (bit_in)
          begin
            if (s_r.ones != `MGMT_PREAMBLE_ONES)
            begin
              s_nxt.ones = s_r.ones + 6'h1; // see [RQ21]
            end
          end
          else if (s_r.ones == `MGMT_PREAMBLE_ONES && bit_in == `MGMT_START_FIRST)
          begin
            s_nxt.state = st_start; // see [RQ16]
            s_nxt.ones = 6'h0;
          end
          else
          begin
            s_nxt.ones = 6'h0;
          end
        end
        // second start bit must match or the frame is dropped
        st_start:
        begin
          s_nxt.cnt = 5'h0;
          s_nxt.state = (bit_in == `MGMT_START_SECOND) ? st_hdr : st_idle; // see [RQ21] [RQ20]
        end
        // opcode, phy address and register address, msb first
        st_hdr:
        begin
          s_nxt.hdr = {s_r.hdr[10:0], bit_in}; // see [RQ11] [RQ5]
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == `MGMT_HDR_LAST)
          begin
            s_nxt.cnt = 5'h0;
            s_nxt.cur_sel = s_nxt.hdr[0]; // see [RQ7]
            s_nxt.addr = {s_nxt.hdr[8:5], s_nxt.hdr[4:1], s_nxt.hdr[0], 1'b0}; // see [RQ6]
            s_nxt.addr[1:0] = 2'b00;
            s_nxt.state = st_idle;
            // lower phy addresses belong to ordinary phys
            if (s_nxt.hdr[5 + `MGMT_CLIENT_PHY_BIT])
            begin
              if (s_nxt.hdr[11:10] == `MGMT_OP_READ) // see [RQ1] [RQ20]
              begin
                s_nxt.state = st_rd_ta;
                if (!s_r.rd_pend)
                begin
                  // first half: fetch the whole word now, hold it for the second
                  s_nxt.rd_strobe = 1'b1; // see [RQ18]
                  s_nxt.rd_pend = 1'b1;
                  s_nxt.rd_sel = s_nxt.hdr[0];
                end
                else if (s_r.rd_sel != s_nxt.hdr[0])
                begin
                  s_nxt.shift = half_of(s_r.rd_hold, s_nxt.hdr[0]); // see [RQ7]
                  s_nxt.rd_pend = 1'b0;
                  s_nxt.rd_done = 1'b1;
                end
                else
                begin
                  // same half twice: pair is void, next read starts over
                  s_nxt.shift = half_of(s_r.rd_hold, s_nxt.hdr[0]); // see [RQ17]
                  s_nxt.rd_pend = 1'b0;
                end
              end
              else if (s_nxt.hdr[11:10] == `MGMT_OP_WRITE) // see [RQ1] [RQ20]
              begin
                s_nxt.state = st_wr_ta;
              end
            end
          end
        end
        // first turnaround left floating; drive zero for the second
        st_rd_ta:
        begin
          s_nxt.dio_out = 1'b0; // see [RQ13]
          s_nxt.dio_oe_n = 1'b0; // see [RQ13]
          s_nxt.state = st_rd_data;
        end
        // sixteen data bits msb first, then release on the following edge
        st_rd_data:
        begin
          if (s_r.cnt == `MGMT_DATA_COUNT)
          begin
            s_nxt.dio_oe_n = `MGMT_OE_OFF; // see [RQ10]
            s_nxt.state = st_idle;
          end
          else
          begin
            s_nxt.dio_out = s_r.shift[15]; // see [RQ11] [RQ9]
            s_nxt.shift = {s_r.shift[14:0], 1'b0};
            s_nxt.cnt = s_r.cnt + 5'h1;
          end
        end
        // host drives the turnaround itself; it is not checked
        st_wr_ta:
        begin
          s_nxt.cnt = s_r.cnt + 5'h1; // see [RQ14]
          if (s_r.cnt == `MGMT_TA_LAST)
          begin
            s_nxt.cnt = 5'h0;
            s_nxt.state = st_wr_data;
          end
        end
        // collect sixteen bits, then pair with the opposite half
        st_wr_data:
        begin
          s_nxt.shift = {s_r.shift[14:0], bit_in}; // see [RQ11]
          s_nxt.cnt = s_r.cnt + 5'h1;
          if (s_r.cnt == `MGMT_DATA_LAST)
          begin
            s_nxt.state = st_idle;
            if (s_r.wr_pend && s_r.wr_sel != s_r.cur_sel)
            begin
              // no address compare: the host keeps the pair atomic
              s_nxt.wr_data = s_r.cur_sel ? {s_nxt.shift, s_r.wr_hold}
                                          : {s_r.wr_hold, s_nxt.shift}; // see [RQ7] [RQ12] [RQ8]
              s_nxt.wr_strobe = 1'b1;
              s_nxt.wr_pend = 1'b0;
            end
            else
            begin
              // a repeated half replaces the held one and waits again
              s_nxt.wr_hold = s_nxt.shift;
              s_nxt.wr_sel = s_r.cur_sel;
              s_nxt.wr_pend = 1'b1;
            end
          end
        end
        default:
        begin
          s_nxt.state = st_idle;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // clock enable freezes everything, pulses included
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.dio_oe_n <= `MGMT_OE_OFF;
      s_r.state <= st_idle;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign mgmt.dev_o = s_r.dio_out;
  assign mgmt.dev_oe_n = s_r.dio_oe_n;
  assign reg_addr = s_r.addr;
  assign rd_strobe = s_r.rd_strobe;
  assign rd_done = s_r.rd_done;
  assign wr_strobe = s_r.wr_strobe;
  assign wr_data = s_r.wr_data;

endmodule

// ### mgmt_cfg.svh
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define MGMT_PREAMBLE_ONES 6'h20
`define MGMT_OP_READ 2'b10
`define MGMT_OP_WRITE 2'b01
`define MGMT_START_PATTERN 2'b01
`define MGMT_START_FIRST 1'b0
`define MGMT_START_SECOND 1'b1
`define MGMT_TA_WRITE 2'b10
`define MGMT_HDR_LAST 5'h0b
`define MGMT_TA_LAST 5'h01
`define MGMT_DATA_LAST 5'h0f
`define MGMT_DATA_COUNT 5'h10
`define MGMT_CLIENT_PHY_BIT 4
`define MGMT_FRAME_LAST 6'h3f
`define MGMT_RD_RELEASE_BIT 6'h2e
`define MGMT_RD_DATA_BIT 6'h30

// ----------------------------------------------------------------------------
// strap and reset values
// ----------------------------------------------------------------------------
`define MGMT_STRAP_REG_MODE 1'b0
`define MGMT_STRAP_SETTLE 2'h3
`define MGMT_OE_OFF 1'b1

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define MGMT_CLK_PERIOD_NS 8
`define MGMT_MDC_HALF_NS 200
`define MGMT_MDC_HALF_CYCLES ((`MGMT_MDC_HALF_NS + `MGMT_CLK_PERIOD_NS - 1) / `MGMT_CLK_PERIOD_NS)

`endif

// ### mgmt_pkg.sv
package mgmt_pkg;

  // --------------------------------------------------------------------------
  // client parser states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle, st_start, st_hdr, st_rd_ta, st_rd_data, st_wr_ta, st_wr_data
  } dev_state_type;

  // --------------------------------------------------------------------------
  // host sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    hs_idle, hs_frame
  } host_state_type;

  // whole state of the register client
  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_d;
    logic dio_s1;
    logic dio_s2;
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_wait;
    logic mode_ok;
    dev_state_type state;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [11:0] hdr;
    logic [15:0] shift;
    logic cur_sel;
    logic dio_out;
    logic dio_oe_n;
    logic rd_pend;
    logic rd_sel;
    logic [31:0] rd_hold;
    logic wr_pend;
    logic wr_sel;
    logic [15:0] wr_hold;
    logic [9:0] addr;
    logic rd_strobe;
    logic rd_done;
    logic wr_strobe;
    logic [31:0] wr_data;
  } dev_regs_type;

  // whole state of the host end
  typedef struct packed {
    host_state_type state;
    logic [15:0] div;
    logic mdc;
    logic [5:0] idx;
    logic half;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [63:0] frame;
    logic dio_out;
    logic dio_oe_n;
    logic dio_s1;
    logic dio_s2;
    logic [15:0] rd16;
    logic [31:0] rdata;
    logic resp_valid;
  } host_regs_type;

endpackage

// ### mgmt_if.sv
interface mgmt_if;
  logic mdc; // management clock, made by the host
  logic host_o; // host data out
  logic host_oe_n; // host drives when low
  logic dev_o; // client data out
  logic dev_oe_n; // client drives when low
  logic mdio; // resolved line level

  // external pull-up holds the idle line high
  assign mdio = !dev_oe_n ? dev_o : (!host_oe_n ? host_o : 1'b1);

  modport device (input mdc, input mdio, output dev_o, output dev_oe_n);
  modport host (output mdc, output host_o, output host_oe_n, input mdio);
endinterface

// ### mgmt_host.sv
`include "mgmt_cfg.svh"

module mgmt_host
  import mgmt_pkg::*;
#(
  parameter int HALF_CYCLES = `MGMT_MDC_HALF_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  mgmt_if.host mgmt,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic resp_valid,
  output logic [31:0] resp_rdata
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // full 64-bit frame; a read carries ones where the client answers
  function automatic logic [63:0] build_frame(input logic wr, input logic [7:0] addr,
                                              input logic half, input logic [31:0] data);
    logic [1:0] op;
    logic [15:0] d;
    op = wr ? `MGMT_OP_WRITE : `MGMT_OP_READ; // see [RQ16] [RQ20]
    d = wr ? (half ? data[31:16] : data[15:0]) : 16'hffff;
    build_frame = {32'hffffffff, `MGMT_START_PATTERN, op, 1'b1, addr[7:4], addr[3:0], half,
                   (wr ? `MGMT_TA_WRITE : 2'b11), d}; // see [RQ14]
  endfunction

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYCLES - 1); // divider terminal count

  host_regs_type h_r; // registered state
  host_regs_type h_nxt; // next state
  logic [5:0] next_idx; // index of the bit about to be launched

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // management clock stands low between commands; bits change on its fall
  always_comb
  begin
    h_nxt = h_r;
    h_nxt.resp_valid = 1'b0;
    h_nxt.dio_s1 = mgmt.mdio;
    h_nxt.dio_s2 = h_r.dio_s1;
    next_idx = h_r.idx + 6'h1;
    case (h_r.state)
      // low half first, then high half, back to back
      hs_idle:
      begin
        if (cmd_valid && ce)
        begin
          h_nxt.state = hs_frame;
          h_nxt.write = cmd_write;
          h_nxt.addr = cmd_addr;
          h_nxt.wdata = cmd_wdata;
          h_nxt.half = 1'b0;
          h_nxt.idx = 6'h0;
          h_nxt.div = 16'h0;
          h_nxt.frame = build_frame(cmd_write, cmd_addr, 1'b0, cmd_wdata);
          h_nxt.dio_out = 1'b1;
          h_nxt.dio_oe_n = 1'b0;
        end
      end
      hs_frame:
      begin
        h_nxt.div = h_r.div + 16'h1;
        if (h_r.div == HALF_LAST)
        begin
          h_nxt.div = 16'h0;
          h_nxt.mdc = !h_r.mdc;
          if (!h_r.mdc)
          begin
            // rising edge: read data is sampled here
            if (!h_r.write && h_r.idx >= `MGMT_RD_DATA_BIT)
            begin
              h_nxt.rd16 = {h_r.rd16[14:0], h_r.dio_s2};
            end
          end
          else if (h_r.idx == `MGMT_FRAME_LAST)
          begin
            // falling edge after the last bit ends this half
            if (!h_r.write)
            begin
              if (h_r.half)
              begin
                h_nxt.rdata[31:16] = h_r.rd16;
              end
              else
              begin
                h_nxt.rdata[15:0] = h_r.rd16;
              end
            end
            if (h_r.half)
            begin
              h_nxt.state = hs_idle;
              h_nxt.dio_oe_n = `MGMT_OE_OFF;
              h_nxt.resp_valid = 1'b1;
            end
            else
            begin
              h_nxt.half = 1'b1;
              h_nxt.idx = 6'h0;
              h_nxt.frame = build_frame(h_r.write, h_r.addr, 1'b1, h_r.wdata); // see [RQ8]
              h_nxt.dio_out = 1'b1;
              h_nxt.dio_oe_n = 1'b0;
            end
          end
          else
          begin
            // falling edge: launch the next bit, release for read answers
            h_nxt.idx = next_idx;
            h_nxt.frame = {h_r.frame[62:0], 1'b0};
            h_nxt.dio_out = h_nxt.frame[63];
            h_nxt.dio_oe_n = (h_r.write || next_idx < `MGMT_RD_RELEASE_BIT) ? 1'b0 : 1'b1;
          end
        end
      end
      default:
      begin
        h_nxt.state = hs_idle;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      h_r <= '0;
      h_r.dio_oe_n <= `MGMT_OE_OFF;
      h_r.state <= hs_idle;
    end
    else if (ce)
    begin
      h_r <= h_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign mgmt.mdc = h_r.mdc;
  assign mgmt.host_o = h_r.dio_out;
  assign mgmt.host_oe_n = h_r.dio_oe_n;
  assign cmd_ready = (h_r.state == hs_idle) && ce;
  assign resp_valid = h_r.resp_valid;
  assign resp_rdata = h_r.rdata;

endmodule

// ### mgmt_client_asserts.sv
module mgmt_client_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic mdc,
  input wire logic host_o,
  input wire logic host_oe_n,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic mdio
);
  timeunit 1ns;
  timeprecision 1ps;

  logic mdc_d_r; // mdc one cycle ago
  logic rise; // mdc rising in this cycle
  logic [3:0] since_rise_r; // cycles since the last mdc rise, saturating
  logic [5:0] ones_r; // run of ones seen at mdc rises
  logic [5:0] since_start_r; // mdc rises since the first start bit
  logic [4:0] drv_rises_r; // mdc rises while the client drives
  logic [1:0] op_r; // opcode of the frame on the line

  assign rise = mdc && !mdc_d_r;

  // --------------------------------------------------------------------------
  // frame position tracking
  // --------------------------------------------------------------------------
  // position is found from the line itself, so a wrong count in either end shows
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mdc_d_r <= 1'b0;
      since_rise_r <= 4'hf;
      ones_r <= 6'h00;
      since_start_r <= 6'h3f;
      drv_rises_r <= 5'h00;
      op_r <= 2'b00;
    end
    else
    begin
      mdc_d_r <= mdc;
      since_rise_r <= rise ? 4'h0 : since_rise_r + {3'h0, since_rise_r != 4'hf};
      drv_rises_r <= dev_oe_n ? 5'h00 : drv_rises_r + {4'h0, rise};
      if (rise)
      begin
        ones_r <= mdio ? ones_r + {5'h0, ones_r != 6'h3f} : 6'h00;
        // a zero after at least 32 ones opens a frame
        if (!mdio && ones_r >= 6'h20)
          since_start_r <= 6'h00;
        else
          since_start_r <= since_start_r + {5'h0, since_start_r != 6'h3f};
        if (since_start_r == 6'h01 || since_start_r == 6'h02)
          op_r <= {op_r[0], mdio};
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_NO_CONTENTION:
    assert property (!(!dev_oe_n && !host_oe_n)) else $error("both ends drive the line");
  AST_RESET_IDLE:
    assert property ($fell(rst) |-> dev_oe_n && host_oe_n && !mdc)
    else $error("link not idle after reset");
  AST_TA_ZERO:
    assert property ($fell(dev_oe_n) |-> !dev_o) else $error("read turnaround not zero");
  AST_DRIVE_SPAN:
    assert property ($rose(dev_oe_n) |-> drv_rises_r == 5'd17)
    else $error("client drive length wrong");
  AST_LAUNCH_AFTER_RISE:
    assert property (($changed(dev_oe_n) || (!dev_oe_n && $changed(dev_o)))
      |-> since_rise_r inside {[4'h1:4'h6]}) else $error("client output not tied to mdc rise");
  AST_DRIVE_POSITION:
    assert property ($fell(dev_oe_n) |-> since_start_r == 6'd14 && op_r == 2'b10)
    else $error("client drives at wrong frame bit");
  AST_HOST_RELEASED:
    assert property (rise && since_start_r == 6'd13 && op_r == 2'b10 |-> host_oe_n)
    else $error("host holds line in read turnaround");
  AST_WRITE_SILENT:
    assert property (op_r == 2'b01 |-> dev_oe_n) else $error("client drives in a write");
  AST_WRITE_TA:
    assert property (rise && op_r == 2'b01 && (since_start_r == 6'd13 || since_start_r == 6'd14)
      |-> mdio == (since_start_r == 6'd13)) else $error("write turnaround wrong");
endmodule

// ### mii_mgmt_register_client_test.sv
module mii_mgmt_register_client_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mgmt_pkg::*;

  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clock, rst, strap, init_done, powered, live;
  logic cmd_valid, cmd_ready, cmd_write, resp_valid, rd_strobe, rd_hit, rd_done, wr_strobe;
  logic [7:0] cmd_addr;
  logic [9:0] reg_addr, wr_a;
  logic [31:0] cmd_wdata, resp_rdata, rd_data, wr_data, wr_d, wword, fr;
  logic [15:0] wtop; // start, opcode, address and turnaround of the last frame
  logic [31:0] mem [0:63]; // register file behind the client
  int miscompares = 0, num_checks = 0, wr_cnt = 0, rs_cnt = 0, dn_cnt = 0;
  typedef struct packed { logic wr; logic [7:0] a; logic [31:0] d; } row_type;
  // rows: write, dword address, write data or expected read data
  row_type rows [0:9] = '{'{1'b1, 8'h01, 32'h1234_5678}, '{1'b1, 8'h3f, 32'hffff_0000},
    '{1'b0, 8'h01, 32'h1234_5678}, '{1'b0, 8'h3f, 32'hffff_0000}, '{1'b1, 8'h20, 32'h0000_ffff},
    '{1'b0, 8'h20, 32'h0000_ffff}, '{1'b0, 8'h40, 32'h0}, '{1'b0, 8'hff, 32'h0},
    '{1'b1, 8'h00, 32'ha5c3_0f81}, '{1'b0, 8'h00, 32'ha5c3_0f81}};

  mgmt_if u_mgmt_if ();
  mgmt_client u_mgmt_client (.clock(clock), .rst(rst), .ce(1'b1), .mgmt(u_mgmt_if.device),
    .mode_strap(strap), .init_done(init_done), .fully_powered(powered), .reg_addr(reg_addr),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_hit(rd_hit), .rd_done(rd_done),
    .wr_strobe(wr_strobe), .wr_data(wr_data));
  // short mdc half period keeps the run brief, still above the client latency
  mgmt_host #(.HALF_CYCLES(5)) u_mgmt_host (.clock(clock), .rst(rst), .ce(1'b1),
    .mgmt(u_mgmt_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata));
  mgmt_client_asserts u_mgmt_client_asserts (.clock(clock), .rst(rst), .mdc(u_mgmt_if.mdc),
    .host_o(u_mgmt_if.host_o), .host_oe_n(u_mgmt_if.host_oe_n), .dev_o(u_mgmt_if.dev_o),
    .dev_oe_n(u_mgmt_if.dev_oe_n), .mdio(u_mgmt_if.mdio));

  // upper addresses are unused; the ones here must never reach the line
  assign rd_hit = reg_addr[9:8] == 2'b00;
  assign rd_data = rd_hit ? mem[reg_addr[7:2]] : 32'hffff_ffff;

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // register side model and line monitor
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (wr_strobe === 1'b1)
    begin
      wr_cnt++;
      wr_d = wr_data;
      wr_a = reg_addr;
      mem[reg_addr[7:2]] <= wr_data;
    end
    if (rd_strobe === 1'b1)
    begin
      rs_cnt++;
      // a live bit changing after the fetch must not reach the host
      if (live)
        mem[reg_addr[7:2]] <= ~rd_data;
    end
    if (rd_done === 1'b1)
      dn_cnt++;
    if (u_mgmt_client_asserts.rise === 1'b1)
    begin
      fr = {fr[30:0], u_mgmt_if.mdio};
      if (u_mgmt_client_asserts.since_start_r == 6'h1e)
      begin
        if (fr[18])
          wword[31:16] = fr[15:0];
        else
          wword[15:0] = fr[15:0];
        wtop = fr[31:16];
      end
    end
  end

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("idle enables", {30'h0, u_mgmt_if.dev_oe_n, u_mgmt_if.host_oe_n}, 32'h3);
    chk("mdc", 32'(u_mgmt_if.mdc), 32'h0);
  endtask

  // one host command; act says whether the client should take part
  task automatic do_cmd(input logic wr, input logic [7:0] a, input logic [31:0] e, input logic act);
    int n, w0, s0, d0;
    w0 = wr_cnt;
    s0 = rs_cnt;
    d0 = dn_cnt;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= e;
    cmd_valid <= 1'b1;
    @(posedge clock);
    for (n = 0; n < 8 && cmd_ready !== 1'b1; n++)
      @(posedge clock);
    if (n == 8)
      chk("cmd_ready", 32'h0, 32'h1);
    cmd_valid <= 1'b0;
    for (n = 0; n < 4000 && resp_valid !== 1'b1; n++)
      @(posedge clock);
    if (n == 4000)
    begin
      chk("resp_valid", 32'h0, 32'h1);
      tally_and_finish();
    end
    if (!wr)
      chk("resp_rdata", resp_rdata, e);
    repeat (20) @(posedge clock);
    chk("line data", wword, e);
    chk("line head", {16'h0, wtop}, {16'h0, 2'b01, wr ? 2'b01 : 2'b10, 1'b1, a, 1'b1,
      (wr || act) ? 2'b10 : 2'b11});
    chk("writes", wr_cnt - w0, (wr && act) ? 1 : 0);
    if (wr && act)
      chk("wr word", wr_d ^ {wr_a, 22'h0}, e ^ {a, 24'h0});
    chk("fetches", rs_cnt - s0, (!wr && act) ? 1 : 0);
    chk("read done", dn_cnt - d0, (!wr && act) ? 1 : 0);
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    strap = 1'b0;
    init_done = 1'b1;
    powered = 1'b1;
    live = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 32'h0;
    do_reset();
    for (int i = 0; i < 10; i++)
    begin
      do_cmd(rows[i].wr, rows[i].a, rows[i].d, 1'b1);
      $display("row %0d done", i);
    end
    live <= 1'b1;
    do_cmd(1'b0, 8'h01, 32'h1234_5678, 1'b1);
    live <= 1'b0;
    do_cmd(1'b0, 8'h01, 32'hedcb_a987, 1'b1);
    $display("live capture done");
    // low power first, then incomplete initialization
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0)
        powered <= 1'b0;
      else
        init_done <= 1'b0;
      do_cmd(1'b1, 8'h01, 32'h0bad_0bad, 1'b0);
      do_cmd(1'b0, 8'h01, 32'hffff_ffff, 1'b0);
      powered <= 1'b1;
      init_done <= 1'b1;
      do_cmd(1'b0, 8'h01, 32'hedcb_a987, 1'b1);
      $display("inactive case %0d done", k);
    end
    strap <= 1'b1;
    do_reset();
    do_cmd(1'b0, 8'h01, 32'hffff_ffff, 1'b0);
    strap <= 1'b0;
    do_reset();
    do_cmd(1'b0, 8'h01, 32'hedcb_a987, 1'b1);
    $display("strap case done");
    tally_and_finish();
  end
endmodule
